/* rtl/csm_consts.svh */
// constants for the clock source select and monitor block
// assumes byte addressing on the register bus, 50 MHz core clock
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH

// register indices; byte address is four times the index
`define CSM_IDX_CTRL       14'hf86
`define CSM_IDX_STAT       14'hf87
`define CSM_IDX_MASK       14'hf88

// clock_source_control reset value and field positions
`define CSM_CTRL_RESET     8'ha0
`define CSM_BIT_IRC_EN     7
`define CSM_BIT_XTAL_EN    6
`define CSM_BIT_WDOG_EN    5
`define CSM_BIT_SOF_EN     4
`define CSM_BIT_WOF_EN     3
`define CSM_SEL_MSB        2

// unlock keys
`define CSM_KEY_FIRST      8'he7
`define CSM_KEY_SECOND     8'h18

// clock select encodings
`define CSM_SEL_IRC_FAST   3'h0
`define CSM_SEL_IRC_SLOW   3'h1
`define CSM_SEL_XTAL       3'h2
`define CSM_SEL_WDOG       3'h3
`define CSM_SEL_EXT_PIN    3'h4
`define CSM_NUM_SRC        5

// status bits
`define CSM_ST_SYSFAIL     0
`define CSM_ST_WDFAIL      1
`define CSM_ST_FORCED      2
`define CSM_ST_WDDEAD      3
`define CSM_NUM_EVT        2

// timing: primary failure below 1 kHz, i.e. no edge for 1000 us
`define CSM_CORE_MHZ       50
`define CSM_PRI_GAP_US     1000
`define CSM_PRI_GAP_CYC    (`CSM_PRI_GAP_US * `CSM_CORE_MHZ)
// watchdog failure: system clock cycles without a watchdog edge
`define CSM_WD_GAP_CYC     8004

`endif

/* rtl/csm_pkg.sv */
// types for the clock source select and monitor block
// assumes csm_consts.svh holds all numbers
package csm_pkg;

  // unlock sequence position of the control register
  typedef enum logic [1:0] {
    csm_lock_closed,
    csm_lock_key1,
    csm_lock_open
  } csm_lock_e;

  typedef logic [7:0] csm_byte_t;

endpackage

/* rtl/csm_gapcount.sv */
// gap counter: flags a failure when too many ticks pass without an edge
// assumes tick and edge_seen are one-cycle strobes on core_clk
`timescale 1ns/1ps
`default_nettype none

module csm_gapcount
  import csm_pkg::*;
#(
  parameter int LIMIT = 8004,
  parameter int W     = $clog2(LIMIT + 1)
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  // monitoring
  input  wire logic enable,
  input  wire logic tick,
  input  wire logic edge_seen,
  // result
  output logic      fail
);

  logic [W-1:0] count_ff;     // ticks since last edge
  logic [W-1:0] nxt_count;
  logic         fail_ff;      // limit reached, level
  logic         nxt_fail;

  // next count; saturates once failed so it never wraps to healthy
  always_comb begin
    nxt_count = count_ff;
    nxt_fail  = fail_ff;
    if (!enable || edge_seen) begin
      nxt_count = '0;
      nxt_fail  = 1'b0;
    end else if (tick && !fail_ff) begin
      nxt_count = count_ff + W'(1);
      if (nxt_count >= W'(LIMIT)) begin
        nxt_fail = 1'b1;
      end
    end
  end

  // register stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= '0;
      fail_ff  <= 1'b0;
    end else if (clk_en) begin
      count_ff <= nxt_count;
      fail_ff  <= nxt_fail;
    end
  end

  assign fail = fail_ff;

endmodule

`default_nettype wire

/* rtl/csm_clkmux.sv */
// glitch-free source switch over sampled oscillator levels
// assumes oscillator levels are synchronous samples on core_clk
`include "csm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module csm_clkmux
  import csm_pkg::*;
#(
  parameter int NSRC = 5
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  input  wire logic            clk_en,
  // sources and wanted select
  input  wire logic [NSRC-1:0] src_lvl,
  input  wire logic [2:0]      want_sel,
  // result
  output logic                 clk_out,
  output logic [2:0]           cur_sel
);

  logic [2:0] sel_ff;       // source now driving the output
  logic [2:0] nxt_sel;
  logic       out_ff;       // registered system clock
  logic       nxt_out;
  logic       pending;      // a different valid source is wanted

  // reserved codes never start a switch; current source keeps running
  assign pending = (want_sel != sel_ff) && (32'(want_sel) < NSRC);

  // no runt pulses
  // old high phase finishes, output parks low, then joins new source low
  always_comb begin
    nxt_sel = sel_ff;
    nxt_out = src_lvl[sel_ff];
    if (pending) begin
      nxt_out = out_ff & src_lvl[sel_ff];
      if (!out_ff && !src_lvl[want_sel]) begin
        nxt_sel = want_sel;
        nxt_out = 1'b0;
      end
    end
  end

  // register stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_ff <= `CSM_SEL_IRC_FAST;
      out_ff <= 1'b0;
    end else if (clk_en) begin
      sel_ff <= nxt_sel;
      out_ff <= nxt_out;
    end
  end

  assign clk_out = out_ff;
  assign cur_sel = sel_ff;

endmodule

`default_nettype wire

/* rtl/csm_top.sv */
// clock source select and monitor: protected control register,
// glitch-free source switch, failure detection and recovery
// assumes oscillator inputs are sampled levels synchronous to core_clk
// and an Avalon-MM master with waitrequest on the register side
//
// Local design decision: the Avalon-MM interface to the registers.
`include "csm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - two keys unlock the control register
// - next write updates, then relocks
// - any other sequence changes nothing
// - keys ordered; other accesses may interleave
// - three-bit field picks the system clock
// - bits 7..3 enable oscillators and detectors
// - internal RC on after reset, until an unlocked control write clears bit 7
// - crystal enable takes over crystal pins
// - primary failure: event plus forced watchdog clock
// - no fallback if watchdog selected or off
// - primary failure below about one kilohertz
// - watchdog failure: event, clock unchanged
// - after watchdog failure, primary detection stops
// - count system clocks awaiting watchdog edge
module csm_top
  import csm_pkg::*;
#(
  parameter int PRI_GAP_CYC = `CSM_PRI_GAP_CYC,
  parameter int WD_GAP_CYC  = `CSM_WD_GAP_CYC
) (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // sampled oscillator levels
  input  wire logic        ipo_fast_clk,
  input  wire logic        ipo_slow_clk,
  input  wire logic        crystal_clk,
  input  wire logic        wdog_osc_clk,
  input  wire logic        external_clock_pin,
  // strap
  input  wire logic        crystal_reset_disable_option,
  // oscillator controls
  output logic             internal_rc_enable,
  output logic             crystal_enable,
  output logic             watchdog_osc_enable,
  // system clock and events
  output logic             sysclk_out,
  output logic             sysclk_fail_nmi,
  output logic             wdog_fail_nmi,
  output logic             irq
);

  // register state
  csm_byte_t                 ctrl_ff;     // clock_source_control
  csm_byte_t                 nxt_ctrl;
  csm_lock_e                 lock_ff;     // unlock sequence position
  csm_lock_e                 nxt_lock;
  logic [`CSM_NUM_EVT-1:0]   stat_ff;     // sticky failure events
  logic [`CSM_NUM_EVT-1:0]   nxt_stat;
  logic [`CSM_NUM_EVT-1:0]   mask_ff;     // interrupt enables
  logic [`CSM_NUM_EVT-1:0]   nxt_mask;
  logic                      forced_ff;   // recovery holds watchdog clock
  logic                      nxt_forced;
  logic                      wddead_ff;   // watchdog failed since reset
  logic                      nxt_wddead;
  logic                      wait_ff;     // waitrequest, idle high
  logic                      nxt_wait;
  logic [31:0]               rdata_ff;    // read data
  logic [31:0]               nxt_rdata;
  logic                      strap_ff;    // strap taken after release
  logic                      nxt_strap;
  logic                      irq_ff;
  logic                      nxt_irq;
  // edge tracking
  logic                      sys_prev_ff;
  logic                      wd_prev_ff;
  logic                      pfail_prev_ff;
  logic                      wfail_prev_ff;

  // datapath wires
  logic [`CSM_NUM_SRC-1:0]   src_lvl;
  logic [2:0]                want_sel;
  logic [2:0]                cur_sel;
  logic                      mux_clk;
  logic                      sys_rise;
  logic                      wd_rise;
  logic                      pri_en;
  logic                      pri_fail;
  logic                      wd_fail;
  logic [`CSM_NUM_EVT-1:0]   evt;
  logic                      hit_ctrl;
  logic                      hit_stat;
  logic                      hit_mask;
  logic                      do_write;
  logic                      ctrl_wr;

  // sources in select-code order
  assign src_lvl = {external_clock_pin, wdog_osc_clk, crystal_clk,
                    ipo_slow_clk, ipo_fast_clk};

  // forced watchdog clock
  // recovery overrides the field without touching the register
  assign want_sel = forced_ff ? `CSM_SEL_WDOG
                              : ctrl_ff[`CSM_SEL_MSB:0];

  csm_clkmux #(
    .NSRC     (`CSM_NUM_SRC)
  ) u_mux (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .src_lvl  (src_lvl),
    .want_sel (want_sel),
    .clk_out  (mux_clk),
    .cur_sel  (cur_sel)
  );

  // rising edges of the system clock and the watchdog oscillator
  assign sys_rise = mux_clk & ~sys_prev_ff;
  assign wd_rise  = wdog_osc_clk & ~wd_prev_ff;

  // primary detection off once watchdog has failed
  // also off while forced: watchdog is then the clock being watched
  assign pri_en = ctrl_ff[`CSM_BIT_SOF_EN] & ~wddead_ff & ~forced_ff;

  // no rising edge for 1 ms means below 1 kHz
  csm_gapcount #(
    .LIMIT     (PRI_GAP_CYC)
  ) u_pri (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .enable    (pri_en),
    .tick      (1'b1),
    .edge_seen (sys_rise),
    .fail      (pri_fail)
  );

  // system clock edges counted per watchdog edge
  csm_gapcount #(
    .LIMIT     (WD_GAP_CYC)
  ) u_wd (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .enable    (ctrl_ff[`CSM_BIT_WOF_EN]),
    .tick      (sys_rise),
    .edge_seen (wd_rise),
    .fail      (wd_fail)
  );

  // one event per failure, on the rising edge of the fail level
  assign evt[`CSM_ST_SYSFAIL] = pri_fail & ~pfail_prev_ff;
  assign evt[`CSM_ST_WDFAIL]  = wd_fail & ~wfail_prev_ff;

  // word decode; printed offsets are indices
  assign hit_ctrl = (avs_address[15:2] == `CSM_IDX_CTRL);
  assign hit_stat = (avs_address[15:2] == `CSM_IDX_STAT);
  assign hit_mask = (avs_address[15:2] == `CSM_IDX_MASK);
  // writes act on the edge where waitrequest is seen low
  assign do_write = avs_write & ~wait_ff & avs_byteenable[0];
  assign ctrl_wr  = do_write & hit_ctrl;

  // sticky status, one bit per event; set beats write-one-clear
  generate
    for (genvar i = 0; i < `CSM_NUM_EVT; i++) begin : g_stat
      always_comb begin
        nxt_stat[i] = stat_ff[i];
        if (do_write && hit_stat && avs_writedata[i]) begin
          nxt_stat[i] = 1'b0;
        end
        if (evt[i]) begin
          nxt_stat[i] = 1'b1;
        end
      end
    end
  endgenerate

  // control, unlock, recovery and bus next state
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_lock   = lock_ff;
    nxt_mask   = mask_ff;
    nxt_forced = forced_ff;
    nxt_wddead = wddead_ff;
    nxt_wait   = wait_ff;
    nxt_rdata  = rdata_ff;
    nxt_strap  = 1'b1;
    // crystal running from reset unless strapped off
    if (!strap_ff && !crystal_reset_disable_option) begin
      nxt_ctrl[`CSM_BIT_XTAL_EN] = 1'b1;
    end
    // bus: one wait state, then a single low cycle of waitrequest
    if (!wait_ff) begin
      nxt_wait = 1'b1;
    end else if (avs_read || avs_write) begin
      nxt_wait  = 1'b0;
      nxt_rdata = '0;
      if (hit_ctrl) begin
        nxt_rdata[7:0] = ctrl_ff;
      end else if (hit_stat) begin
        nxt_rdata[`CSM_NUM_EVT-1:0] = stat_ff;
        nxt_rdata[`CSM_ST_FORCED]   = forced_ff;
        nxt_rdata[`CSM_ST_WDDEAD]   = wddead_ff;
        nxt_rdata[10:8]             = cur_sel;
      end else if (hit_mask) begin
        nxt_rdata[`CSM_NUM_EVT-1:0] = mask_ff;
      end
    end
    // only control writes move the sequence
    if (ctrl_wr) begin
      case (lock_ff)
        csm_lock_closed: begin
          if (avs_writedata[7:0] == `CSM_KEY_FIRST) begin
            nxt_lock = csm_lock_key1;
          end
        end
        // wrong second key drops back, first key rearms
        csm_lock_key1: begin
          if (avs_writedata[7:0] == `CSM_KEY_SECOND) begin
            nxt_lock = csm_lock_open;
          end else if (avs_writedata[7:0] == `CSM_KEY_FIRST) begin
            nxt_lock = csm_lock_key1;
          end else begin
            nxt_lock = csm_lock_closed;
          end
        end
        csm_lock_open: begin
          nxt_ctrl   = avs_writedata[7:0];
          nxt_lock   = csm_lock_closed;
          nxt_forced = 1'b0;
        end
        default: begin
          nxt_lock = csm_lock_closed;
        end
      endcase
    end
    if (do_write && hit_mask) begin
      nxt_mask = avs_writedata[`CSM_NUM_EVT-1:0];
    end
    // fallback needs a running, unselected watchdog
    if (evt[`CSM_ST_SYSFAIL] && ctrl_ff[`CSM_BIT_WDOG_EN]
        && (ctrl_ff[`CSM_SEL_MSB:0] != `CSM_SEL_WDOG)) begin
      nxt_forced = 1'b1;
    end
    // watchdog failure only flags, no source change
    if (evt[`CSM_ST_WDFAIL]) begin
      nxt_wddead = 1'b1;
    end
    nxt_irq = |(nxt_stat & nxt_mask);
  end

  // register stage; everything freezes while clk_en is low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      // internal RC enabled out of reset
      ctrl_ff       <= `CSM_CTRL_RESET;
      lock_ff       <= csm_lock_closed;
      stat_ff       <= '0;
      mask_ff       <= '0;
      forced_ff     <= 1'b0;
      wddead_ff     <= 1'b0;
      wait_ff       <= 1'b1;
      rdata_ff      <= '0;
      strap_ff      <= 1'b0;
      irq_ff        <= 1'b0;
      sys_prev_ff   <= 1'b0;
      wd_prev_ff    <= 1'b0;
      pfail_prev_ff <= 1'b0;
      wfail_prev_ff <= 1'b0;
    end else if (clk_en) begin
      ctrl_ff       <= nxt_ctrl;
      lock_ff       <= nxt_lock;
      stat_ff       <= nxt_stat;
      mask_ff       <= nxt_mask;
      forced_ff     <= nxt_forced;
      wddead_ff     <= nxt_wddead;
      wait_ff       <= nxt_wait;
      rdata_ff      <= nxt_rdata;
      strap_ff      <= nxt_strap;
      irq_ff        <= nxt_irq;
      sys_prev_ff   <= mux_clk;
      wd_prev_ff    <= wdog_osc_clk;
      pfail_prev_ff <= pri_fail;
      wfail_prev_ff <= wd_fail;
    end
  end

  assign internal_rc_enable  = ctrl_ff[`CSM_BIT_IRC_EN];
  // this level also hands both crystal pins to the crystal
  assign crystal_enable      = ctrl_ff[`CSM_BIT_XTAL_EN];
  assign watchdog_osc_enable = ctrl_ff[`CSM_BIT_WDOG_EN];
  // non-maskable requests are the raw sticky bits
  assign sysclk_fail_nmi     = stat_ff[`CSM_ST_SYSFAIL];
  assign wdog_fail_nmi       = stat_ff[`CSM_ST_WDFAIL];
  assign irq                 = irq_ff;
  assign sysclk_out          = mux_clk;
  assign avs_readdata        = rdata_ff;
  assign avs_waitrequest     = wait_ff;

endmodule

`default_nettype wire

/* verif/csm_top_props.sv */
// checker for csm_top: bus handshake, locking, events, detector timing
// assumes clk_en high in normal runs and one core_clk domain
`timescale 1ns/1ps
`default_nettype none

module csm_top_props #(
  parameter int PRI_GAP_CYC = 40,
  parameter int WD_GAP_CYC  = 12
) (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic [15:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        wdog_osc_clk,
  input wire logic        internal_rc_enable,
  input wire logic        watchdog_osc_enable,
  input wire logic        sysclk_out,
  input wire logic        sysclk_fail_nmi,
  input wire logic        wdog_fail_nmi,
  input wire logic        irq
);
  // completed writes, qualified by lane 0
  logic done_wr;
  logic ctl_wr;
  logic st_clr0;
  logic st_clr1;
  assign done_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign ctl_wr  = done_wr & (avs_address == 16'h3e18);
  assign st_clr0 = done_wr & (avs_address == 16'h3e1c) & avs_writedata[0];
  assign st_clr1 = done_wr & (avs_address == 16'h3e1c) & avs_writedata[1];

  // gap counters: cycles since a sysclk rise, sysclk rises since a
  // watchdog rise; int width so no wrap within a run
  logic sys_q_ff, wd_q_ff, nxt_sys_q, nxt_wd_q;
  int   gap_ff, wdc_ff, nxt_gap, nxt_wdc;
  always_comb begin
    nxt_sys_q = sysclk_out;
    nxt_wd_q  = wdog_osc_clk;
    nxt_gap   = (sysclk_out & ~sys_q_ff) ? 0 : gap_ff + 1;
    nxt_wdc   = (wdog_osc_clk & ~wd_q_ff) ? 0 :
                wdc_ff + int'(sysclk_out & ~sys_q_ff);
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {sys_q_ff, wd_q_ff, gap_ff, wdc_ff} <= '0;
    end else begin
      {sys_q_ff, wd_q_ff, gap_ff, wdc_ff} <=
        {nxt_sys_q, nxt_wd_q, nxt_gap, nxt_wdc};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_wait_one_cycle: assert property ((avs_read | avs_write) &&
    avs_waitrequest && clk_en |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("answer not exactly one cycle");
  a_wait_needs_req: assert property ($fell(avs_waitrequest) |->
    $past(avs_read | avs_write)) else $error("answer without request");
  a_irq_has_cause: assert property (irq |->
    sysclk_fail_nmi || wdog_fail_nmi) else $error("irq without event");
  a_sys_evt_sticky: assert property (sysclk_fail_nmi && !st_clr0 |=>
    sysclk_fail_nmi) else $error("system fail event dropped");
  a_wd_evt_sticky: assert property (wdog_fail_nmi && !st_clr1 |=>
    wdog_fail_nmi) else $error("watchdog fail event dropped");
  a_rc_on_reset: assert property ($rose(arst_n) |->
    internal_rc_enable && watchdog_osc_enable)
    else $error("oscillator enables wrong after reset");
  a_ctrl_locked: assert property ($changed(internal_rc_enable) ||
    $changed(watchdog_osc_enable) |-> $past(ctl_wr))
    else $error("enable changed without control write");
  a_pri_gap_min: assert property ($rose(sysclk_fail_nmi) |->
    gap_ff >= PRI_GAP_CYC) else $error("system fail raised early");
  a_wd_gap_min: assert property ($rose(wdog_fail_nmi) |->
    wdc_ff >= WD_GAP_CYC) else $error("watchdog fail raised early");
endmodule

bind csm_top csm_top_props #(
  .PRI_GAP_CYC(PRI_GAP_CYC),
  .WD_GAP_CYC (WD_GAP_CYC)
) u_csm_top_props (
  .core_clk, .arst_n, .clk_en, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .wdog_osc_clk,
  .internal_rc_enable, .watchdog_osc_enable, .sysclk_out,
  .sysclk_fail_nmi, .wdog_fail_nmi, .irq
);
`default_nettype wire

/* verif/csm_osc_model.sv */
// oscillator model: sampled levels of the five clock sources
// assumes levels are produced on core_clk; stop inputs fake failures
`timescale 1ns/1ps
`default_nettype none

module csm_osc_model #(
  parameter int XTAL_SETTLE = 8
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // enables and failure commands
  input  wire logic irc_on,
  input  wire logic xtal_on,
  input  wire logic wdog_on,
  input  wire logic stop_fast,
  input  wire logic stop_wdog,
  // levels
  output logic      fast_lvl,
  output logic      slow_lvl,
  output logic      xtal_lvl,
  output logic      wdog_lvl,
  output logic      ext_lvl
);
  int cnt;   // free phase counter
  int xset;  // crystal start-up count
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 0;
      xset <= 0;
    end else begin
      cnt  <= cnt + 1;
      xset <= xtal_on ? ((xset < XTAL_SETTLE) ? xset + 1 : xset) : 0;
    end
  end
  // a disabled or failed oscillator sits low
  assign fast_lvl = irc_on & ~stop_fast & cnt[0];
  assign slow_lvl = irc_on & cnt[2];
  assign xtal_lvl = (xset == XTAL_SETTLE) & cnt[1];
  assign wdog_lvl = wdog_on & ~stop_wdog & ((cnt % 6) < 3);
  assign ext_lvl  = (cnt % 10) < 5;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for csm_top with oscillator model
// assumes the bound checker and short detector gaps
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [15:0] A_CTRL = 16'h3e18;
  localparam logic [15:0] A_STAT = 16'h3e1c;
  localparam logic [15:0] A_MASK = 16'h3e20;
  logic        core_clk = 1'b0, arst_n = 1'b0;
  logic [15:0] avs_address = '0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = '0, avs_readdata, r;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        avs_waitrequest, stop_fast = 1'b0, stop_wdog = 1'b0;
  logic        xtal_off = 1'b1;  // crystal strap, high keeps it off
  logic        fast, slow, xtal, wdog, ext, rc_en, x_en, wd_en;
  logic        sysclk_out, sys_nmi, wd_nmi, irq;
  int          err_total = 0, tests_run = 0;

  always #10 core_clk = ~core_clk;

  csm_top #(.PRI_GAP_CYC(40), .WD_GAP_CYC(12)) u_csm_top (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ipo_fast_clk(fast),
    .ipo_slow_clk(slow), .crystal_clk(xtal), .wdog_osc_clk(wdog),
    .external_clock_pin(ext), .crystal_reset_disable_option(xtal_off),
    .internal_rc_enable(rc_en), .crystal_enable(x_en),
    .watchdog_osc_enable(wd_en), .sysclk_out(sysclk_out),
    .sysclk_fail_nmi(sys_nmi), .wdog_fail_nmi(wd_nmi), .irq(irq));

  csm_osc_model u_csm_osc_model (
    .core_clk(core_clk), .arst_n(arst_n), .irc_on(rc_en),
    .xtal_on(x_en), .wdog_on(wd_en), .stop_fast(stop_fast),
    .stop_wdog(stop_wdog), .fast_lvl(fast), .slow_lvl(slow),
    .xtal_lvl(xtal), .wdog_lvl(wdog), .ext_lvl(ext));

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      err_total++;
    end
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    if (n >= 50) chk(1, 0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask

  task unlock_wr(input logic [7:0] d);
    bus(1, A_CTRL, 32'he7);
    bus(1, A_CTRL, 32'h18);
    bus(1, A_CTRL, {24'h0, d});
  endtask

  task automatic wait_for(input int lim, ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task t_reset_map;
    bus(0, A_CTRL, 0); chk(r, 32'ha0);
    bus(0, A_STAT, 0); chk(r, 32'h0);
    bus(0, 16'h0040, 0); chk(r, 32'h0);
  endtask

  task t_lock;
    bus(1, A_CTRL, 32'h00);
    bus(1, A_CTRL, 32'h18);
    bus(1, A_CTRL, 32'he7);
    bus(1, A_CTRL, 32'h55);
    bus(1, A_CTRL, 32'h41);
    bus(0, A_CTRL, 0); chk(r, 32'ha0);
    avs_byteenable <= 4'he;
    bus(1, A_MASK, 32'h3);
    avs_byteenable <= 4'hf;
    bus(0, A_MASK, 0); chk(r, 32'h0);
    bus(1, A_CTRL, 32'he7);
    bus(0, A_STAT, 0);
    bus(1, A_CTRL, 32'h18);
    bus(1, A_MASK, 32'h0);
    bus(1, A_CTRL, 32'hc0);
    bus(0, A_CTRL, 0); chk(r, 32'hc0);
    chk(x_en, 1);
    bus(1, A_CTRL, 32'ha0);
    bus(0, A_CTRL, 0); chk(r, 32'hc0);
  endtask

  // select codes 0 to 5, detectors kept off while switching
  task t_select;
    for (int c = 0; c < 6; c++) begin
      unlock_wr(8'he0 | c[7:0]);
      repeat (40) @(posedge core_clk);
      bus(0, A_STAT, 0);
      chk(r[10:8], (c < 5) ? c : 4);
    end
    unlock_wr(8'ha0);
    chk(rc_en, 1);
  endtask

  task t_pri_fail(input logic wd_on, input logic [1:0] msk);
    bus(1, A_MASK, {30'h0, msk});
    unlock_wr(wd_on ? 8'hb0 : 8'h90);
    repeat (8) @(posedge core_clk);
    stop_fast <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk(sys_nmi, 0);
    wait_for(100, sys_nmi);
    chk(sys_nmi, 1);
    repeat (20) @(posedge core_clk);
    bus(0, A_STAT, 0);
    chk({r[10:8], r[2]}, wd_on ? 4'h7 : 4'h0);
    chk(irq, msk[0]);
    stop_fast <= 1'b0;
    unlock_wr(8'ha0);
    repeat (8) @(posedge core_clk);
    bus(1, A_STAT, 32'h1);
    chk(sys_nmi, 0);
    bus(0, A_STAT, 0); chk(r[2:0], 3'h0);
  endtask

  task t_wd_fail;
    bus(1, A_MASK, 32'h2);
    unlock_wr(8'ha8);
    repeat (20) @(posedge core_clk);
    stop_wdog <= 1'b1;
    repeat (15) @(posedge core_clk);
    chk(wd_nmi, 0);
    wait_for(200, wd_nmi);
    chk(wd_nmi, 1);
    chk(irq, 1);
    bus(0, A_STAT, 0); chk({r[10:8], r[3]}, 4'h1);
    unlock_wr(8'ha0);
    bus(1, A_STAT, 32'h2);
    unlock_wr(8'hb0);
    stop_fast <= 1'b1;
    repeat (120) @(posedge core_clk);
    chk(sys_nmi, 0);
  endtask

  // mid-run reset with the crystal strap low: crystal on from reset
  task t_strap;
    stop_fast <= 1'b0;
    stop_wdog <= 1'b0;
    xtal_off  <= 1'b0;
    arst_n    <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    bus(0, A_CTRL, 0); chk(r, 32'he0);
    chk(x_en, 1);
    bus(0, A_STAT, 0); chk(r, 32'h0);
  endtask

  task results;
    $display("errors %0d in %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset_map;
    t_lock;
    t_select;
    t_pri_fail(1'b0, 2'h0);
    t_pri_fail(1'b1, 2'h1);
    t_wd_fail;
    t_strap;
    results;
  end

  // hang guard, far beyond the roughly 800 cycles needed
  initial begin
    #400000;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
